// file: design/pcu_consts.svh
`ifndef PCU_CONSTS_SVH
`define PCU_CONSTS_SVH
// ---------------------------------------------------------------
// widths and counts
// ---------------------------------------------------------------
`define PCU_NPRED 64
`define PCU_PIDX_W 6
`define PCU_GIDX_W 7
`define PCU_DATA_W 64
`define PCU_LANES 2
`define PCU_PR_RESET 64'h0000000000000001
// ---------------------------------------------------------------
// integer relation codes
// ---------------------------------------------------------------
`define REL_EQ 4'h0
`define REL_NE 4'h1
`define REL_LT 4'h2
`define REL_LE 4'h3
`define REL_GT 4'h4
`define REL_GE 4'h5
`define REL_LTU 4'h6
`define REL_LEU 4'h7
`define REL_GTU 4'h8
`define REL_GEU 4'h9
// ---------------------------------------------------------------
// floating-point relation codes
// ---------------------------------------------------------------
`define FREL_EQ 4'h0
`define FREL_LT 4'h1
`define FREL_LE 4'h2
`define FREL_UNORD 4'h3
`define FREL_NEQ 4'h4
`define FREL_NLT 4'h5
`define FREL_NLE 4'h6
`define FREL_ORD 4'h7
// ---------------------------------------------------------------
// classify mask bit positions (in imm)
// ---------------------------------------------------------------
`define FC_POS 0
`define FC_NEG 1
`define FC_ZERO 2
`define FC_UNORM 3
`define FC_NORM 4
`define FC_INF 5
`define FC_SNAN 6
`define FC_QNAN 7
`define FC_DEFERRED_FLOAT_TOKEN 8
// ---------------------------------------------------------------
// double-precision field positions
// ---------------------------------------------------------------
`define FP_SIGN 63
`define FP_EXP_HI 62
`define FP_EXP_LO 52
`define FP_FRAC_HI 51
`define FP_QUIET 51
`endif

// file: design/pcu_pkg.sv
package pcu_pkg;
`include "pcu_consts.svh"
   typedef enum logic [3:0]
   {
      K_OTHER = 4'h0, K_ICMP = 4'h1, K_TBIT = 4'h2, K_TNAT = 4'h3,
      K_FCMP = 4'h4, K_FCLASS = 4'h5, K_RCPA = 4'h6, K_RSQA = 4'h7,
      K_MOVL = 4'h8, K_ADDI22 = 4'h9
   } kind_t;
   typedef enum logic [2:0]
   {
      CT_NORM = 3'h0, CT_UNC = 3'h1, CT_AND = 3'h2, CT_ANDCM = 3'h3,
      CT_OR = 3'h4, CT_ORCM = 3'h5, CT_OR_ANDCM = 3'h6,
      CT_AND_ORCM = 3'h7
   } ctype_t;
   typedef struct packed
   {
      logic valid;
      kind_t kind;
      ctype_t ctype;
      logic [3:0] rel;
      logic is_32;
      logic unpred;
      logic [`PCU_PIDX_W-1:0] qp;
      logic [`PCU_PIDX_W-1:0] p1;
      logic [`PCU_PIDX_W-1:0] p2;
      logic [`PCU_GIDX_W-1:0] a_idx;
      logic [`PCU_GIDX_W-1:0] dst;
      logic [`PCU_DATA_W-1:0] a;
      logic [`PCU_DATA_W-1:0] b;
      logic a_nat;
      logic b_nat;
      logic b_zero;
      logic [`PCU_DATA_W-1:0] imm;
   } op_t;
   typedef struct packed
   {
      logic valid;
      logic [`PCU_GIDX_W-1:0] idx;
      logic [`PCU_DATA_W-1:0] data;
      logic deferred_token_bit;
   } gr_wr_t;
endpackage : pcu_pkg

// file: design/predicate_compare_unit.sv
// Functional notes
// - long move writes full 64-bit constant
// - general register zero always reads zero
// - false qualifier leaves state untouched, except unconditional and approximation targets
// - predicates one bit, predicate zero true
// - listed control instructions ignore predicate
// - compares except approximations write two targets
// - ten integer relations, 32-bit uses low half
// - bit test and deferral-flag test
// - eight float relations and float classify
// - approximation sets target when valid
// - normal type writes result and complement
// - unconditional type zeroes targets when false
// - and types clear both on match
// - or types set both on match
// - mixed types: first target takes the first-named part, second the other
// - parallel same-type compares share targets
// - deferred token clears targets, or and mixed types leave them
// - token rule skips flag test, classify of the token class
// - type subsets per instruction family
// - approximations only unconditional, no relation
`timescale 1ns/1ps
module predicate_compare_unit
   import pcu_pkg::*;
#(
   parameter int LANES = `PCU_LANES
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // issued operations, one per lane
   input op_t op [LANES],
   // results
   output logic [`PCU_NPRED-1:0] pred_file,
   output gr_wr_t gr_wr [LANES],
   output logic [LANES-1:0] exec_en,
   output logic [LANES-1:0] illegal
);
   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   function automatic logic fp_nan(input logic [63:0] x);
      fp_nan = (&x[`FP_EXP_HI:`FP_EXP_LO]) && (|x[`FP_FRAC_HI:0]);
   endfunction : fp_nan

   function automatic logic fp_zero(input logic [63:0] x);
      fp_zero = ~|x[`FP_EXP_HI:0];
   endfunction : fp_zero

   function automatic logic fp_norm(input logic [63:0] x);
      fp_norm = (|x[`FP_EXP_HI:`FP_EXP_LO])
         && !(&x[`FP_EXP_HI:`FP_EXP_LO]);
   endfunction : fp_norm

   // ordered less-than; signed zeros compare equal
   function automatic logic fp_lt(input logic [63:0] x,
                                  input logic [63:0] y);
      if (fp_nan(x) || fp_nan(y) || (fp_zero(x) && fp_zero(y)))
         fp_lt = 1'b0;
      else if (x[`FP_SIGN] != y[`FP_SIGN])
         fp_lt = x[`FP_SIGN];
      else if (x[`FP_SIGN])
         fp_lt = x[62:0] > y[62:0];
      else
         fp_lt = x[62:0] < y[62:0];
   endfunction : fp_lt

   function automatic logic fp_eq(input logic [63:0] x,
                                  input logic [63:0] y);
      fp_eq = !fp_nan(x) && !fp_nan(y)
         && (x == y || (fp_zero(x) && fp_zero(y)));
   endfunction : fp_eq

   function automatic logic type_ok(input op_t o);
      logic par;
      par = o.ctype != CT_NORM && o.ctype != CT_UNC;
      case (o.kind)
         K_ICMP: type_ok = (o.rel <= `REL_GEU) && (!par
            || o.rel == `REL_EQ || o.rel == `REL_NE
            || (o.b_zero && o.rel >= `REL_LT && o.rel <= `REL_GE));
         K_TBIT, K_TNAT: type_ok = 1'b1;
         K_FCMP: type_ok = !par && o.rel <= `FREL_ORD;
         K_FCLASS: type_ok = !par;
         K_RCPA, K_RSQA: type_ok = o.ctype == CT_UNC;
         default: type_ok = 1'b1;
      endcase
   endfunction : type_ok

   // ---------------------------------------------------------------
   // per-lane evaluation
   // ---------------------------------------------------------------
   logic [`PCU_NPRED-1:0] pred;
   logic [LANES-1:0] qpv, w1_en, w1_val, w2_en, w2_val, ok;
   logic [`PCU_DATA_W-1:0] av [LANES];

   for (genvar l = 0; l < LANES; l++)
   begin : g_lane
      logic res, deferred_token_bit, cls_hit;
      logic [63:0] x, y;
      logic [`FP_EXP_HI-`FP_EXP_LO:0] ex;
      // operand fetch and relation evaluation
      always_comb
      begin
         av[l] = (op[l].a_idx == '0) ? '0 : op[l].a;
         qpv[l] = (op[l].qp == '0) ? 1'b1 : pred[op[l].qp];
         ok[l] = type_ok(op[l]);
         ex = op[l].a[`FP_EXP_HI:`FP_EXP_LO];
         x = op[l].is_32 ? {{32{av[l][31]}}, av[l][31:0]} : av[l];
         y = op[l].is_32 ? {{32{op[l].b[31]}}, op[l].b[31:0]} : op[l].b;
         if (op[l].is_32 && op[l].rel >= `REL_LTU)
         begin
            x = {32'h00000000, av[l][31:0]};
            y = {32'h00000000, op[l].b[31:0]};
         end
         deferred_token_bit = op[l].a_nat || op[l].b_nat;
         cls_hit = ((op[l].imm[`FC_POS] && !op[l].a[`FP_SIGN])
            || (op[l].imm[`FC_NEG] && op[l].a[`FP_SIGN]))
            && ((op[l].imm[`FC_ZERO] && fp_zero(op[l].a))
            || (op[l].imm[`FC_UNORM] && ex == '0 && !fp_zero(op[l].a))
            || (op[l].imm[`FC_NORM] && fp_norm(op[l].a))
            || (op[l].imm[`FC_INF] && (&ex) && !fp_nan(op[l].a))
            || (op[l].imm[`FC_SNAN] && fp_nan(op[l].a)
               && !op[l].a[`FP_QUIET])
            || (op[l].imm[`FC_QNAN] && fp_nan(op[l].a)
               && op[l].a[`FP_QUIET]));
         res = 1'b0;
         case (op[l].kind)
            K_ICMP:
               case (op[l].rel)
                  `REL_EQ: res = x == y;
                  `REL_NE: res = x != y;
                  `REL_LT: res = $signed(x) < $signed(y);
                  `REL_LE: res = $signed(x) <= $signed(y);
                  `REL_GT: res = $signed(x) > $signed(y);
                  `REL_GE: res = $signed(x) >= $signed(y);
                  `REL_LTU: res = x < y;
                  `REL_LEU: res = x <= y;
                  `REL_GTU: res = x > y;
                  `REL_GEU: res = x >= y;
                  default: res = 1'b0;
               endcase
            K_TBIT: res = av[l][op[l].imm[5:0]];
            K_TNAT: res = op[l].a_idx != '0 && op[l].a_nat;
            K_FCMP:
               case (op[l].rel)
                  `FREL_EQ: res = fp_eq(op[l].a, op[l].b);
                  `FREL_LT: res = fp_lt(op[l].a, op[l].b);
                  `FREL_LE: res = fp_lt(op[l].a, op[l].b)
                     || fp_eq(op[l].a, op[l].b);
                  `FREL_UNORD: res = fp_nan(op[l].a) || fp_nan(op[l].b);
                  `FREL_NEQ: res = !fp_eq(op[l].a, op[l].b);
                  `FREL_NLT: res = !fp_lt(op[l].a, op[l].b);
                  `FREL_NLE: res = !(fp_lt(op[l].a, op[l].b)
                     || fp_eq(op[l].a, op[l].b));
                  `FREL_ORD: res = !fp_nan(op[l].a) && !fp_nan(op[l].b);
                  default: res = 1'b0;
               endcase
            K_FCLASS: res = cls_hit || (op[l].imm[`FC_DEFERRED_FLOAT_TOKEN] && deferred_token_bit);
            K_RCPA: res = !deferred_token_bit && fp_norm(op[l].a) && fp_norm(op[l].b);
            K_RSQA: res = !deferred_token_bit && fp_norm(op[l].a) && !op[l].a[`FP_SIGN];
            default: res = 1'b0;
         endcase
         // token rule skips flag test and tested class
         if (op[l].kind == K_TNAT || op[l].kind == K_RCPA
             || op[l].kind == K_RSQA
             || (op[l].kind == K_FCLASS && op[l].imm[`FC_DEFERRED_FLOAT_TOKEN]))
            deferred_token_bit = 1'b0;
      end

      // target write decode
      always_comb
      begin
         w1_en[l] = 1'b0;
         w2_en[l] = 1'b0;
         w1_val[l] = 1'b0;
         w2_val[l] = 1'b0;
         if (op[l].kind == K_RCPA || op[l].kind == K_RSQA)
         begin
            w1_en[l] = 1'b1;
            w1_val[l] = qpv[l] && res;
         end
         else if (deferred_token_bit)
         begin
            case (op[l].ctype)
               CT_UNC: w1_en[l] = 1'b1;
               CT_NORM, CT_AND, CT_ANDCM: w1_en[l] = qpv[l];
               default: w1_en[l] = 1'b0;
            endcase
            w2_en[l] = w1_en[l];
         end
         else
         begin
            case (op[l].ctype)
               CT_NORM:
               begin
                  w1_en[l] = qpv[l];
                  w1_val[l] = res;
                  w2_val[l] = !res;
               end
               CT_UNC:
               begin
                  w1_en[l] = 1'b1;
                  w1_val[l] = qpv[l] && res;
                  w2_val[l] = qpv[l] && !res;
               end
               CT_AND: w1_en[l] = qpv[l] && !res;
               CT_ANDCM: w1_en[l] = qpv[l] && res;
               CT_OR:
               begin
                  w1_en[l] = qpv[l] && res;
                  w1_val[l] = 1'b1;
                  w2_val[l] = 1'b1;
               end
               CT_ORCM:
               begin
                  w1_en[l] = qpv[l] && !res;
                  w1_val[l] = 1'b1;
                  w2_val[l] = 1'b1;
               end
               // or part first, and part second
               CT_OR_ANDCM:
               begin
                  w1_en[l] = qpv[l] && res;
                  w1_val[l] = 1'b1;
               end
               default:
               begin
                  w1_en[l] = qpv[l] && !res;
                  w2_val[l] = 1'b1;
               end
            endcase
            w2_en[l] = w1_en[l];
         end
         if (!op[l].valid || !ok[l] || op[l].kind == K_OTHER
             || op[l].kind == K_MOVL || op[l].kind == K_ADDI22)
         begin
            w1_en[l] = 1'b0;
            w2_en[l] = 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // predicate file
   // ---------------------------------------------------------------
   // lanes merge in order; legal parallel writes agree in value
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         pred <= `PCU_PR_RESET;
      else
      begin
         for (int l = 0; l < LANES; l++)
         begin
            // several lanes may hit one target
            if (w1_en[l] && op[l].p1 != '0)
               pred[op[l].p1] <= w1_val[l];
            if (w2_en[l] && op[l].p2 != '0)
               pred[op[l].p2] <= w2_val[l];
         end
      end
   end

   // published copy keeps the output a flop
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         pred_file <= `PCU_PR_RESET;
      else
         pred_file <= {pred[`PCU_NPRED-1:1], 1'b1};
   end

   // ---------------------------------------------------------------
   // general register writes, gating and illegal flags
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         exec_en <= '0;
         illegal <= '0;
         for (int l = 0; l < LANES; l++)
            gr_wr[l] <= '0;
      end
      else
      begin
         for (int l = 0; l < LANES; l++)
         begin
            // side effects only with a true qualifier; exec_en also when unpred
            exec_en[l] <= op[l].valid && op[l].kind == K_OTHER
               && (op[l].unpred || qpv[l]);
            illegal[l] <= op[l].valid && !ok[l];
            gr_wr[l].valid <= op[l].valid && qpv[l]
               && (op[l].kind == K_MOVL || op[l].kind == K_ADDI22);
            gr_wr[l].idx <= op[l].dst;
            gr_wr[l].deferred_token_bit <= op[l].kind == K_ADDI22
               && op[l].a_idx != '0 && op[l].a_nat;
            // long move takes the whole immediate
            // zero register plus immediate loads a constant
            gr_wr[l].data <= (op[l].kind == K_MOVL) ? op[l].imm
               : av[l] + {{42{op[l].imm[21]}}, op[l].imm[21:0]};
         end
      end
   end

   // ---------------------------------------------------------------
   // checks (lane 0 acting alone)
   // ---------------------------------------------------------------
   op_t q;
   logic q_v, q_qp;
   logic [`PCU_NPRED-1:0] q_pred;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         q_v <= 1'b0;
      else
         q_v <= op[0].valid && ok[0]
            && (LANES == 1 || !(|w1_en[LANES-1:1]));
      q <= op[0];
      q_qp <= qpv[0];
      q_pred <= pred;
   end

   chk_pr0_true: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pred_file[0] && pred[0])
      else $error("predicate zero not true");
   chk_unc_false: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_v && q.kind == K_ICMP && q.ctype == CT_UNC && !q_qp
      && q.p1 != '0 |-> !pred[q.p1])
      else $error("unconditional false did not clear");
   chk_normal_eq: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_v && q.kind == K_ICMP && q.ctype == CT_NORM && q_qp
      && q.rel == `REL_EQ && !q.a_nat && !q.b_nat && q.a_idx != '0
      && q.p1 != '0 && q.p1 != q.p2 |->
      pred[q.p1] == (q.is_32 ? q.a[31:0] == q.b[31:0] : q.a == q.b))
      else $error("equality compare wrong");
   chk_qp_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_v && q.ctype == CT_NORM && !q_qp && q.kind != K_RCPA
      |-> pred[q.p1] == q_pred[q.p1] && pred[q.p2] == q_pred[q.p2])
      else $error("false qualifier changed a target");
   chk_or_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_v && q.kind == K_TBIT && q.ctype == CT_OR && q_qp
      && !q.a_nat && q.a_idx != '0 && q.a[q.imm[5:0]] && q.p2 != '0
      |-> pred[q.p2])
      else $error("or type did not set");
   chk_and_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_v && q.kind == K_TBIT && q.ctype == CT_AND && q_qp
      && !q.a_nat && q.a_idx != '0 && !q.a[q.imm[5:0]] && q.p1 != '0
      |-> !pred[q.p1])
      else $error("and type did not clear");
   chk_nat_or: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_v && q.kind == K_ICMP && q.ctype == CT_OR && (q.a_nat || q.b_nat)
      |-> pred == q_pred)
      else $error("or type wrote on deferred token");
   chk_movl_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
      op[0].valid && op[0].kind == K_MOVL && qpv[0]
      |=> gr_wr[0].valid && gr_wr[0].data == $past(op[0].imm))
      else $error("long move data wrong");
   chk_zero_reg: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_v && q.kind == K_ADDI22 && q_qp && q.a_idx == '0
      |-> gr_wr[0].data[21:0] == q.imm[21:0] && !gr_wr[0].deferred_token_bit)
      else $error("zero register not zero");
   chk_unpred_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
      op[0].valid && op[0].kind == K_OTHER && op[0].unpred
      |=> exec_en[0])
      else $error("unpredicated instruction gated");
endmodule : predicate_compare_unit

// file: test/gen_reg_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// general register file behind the unit
// ---------------------------------------------
module gen_reg_model
   import pcu_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // write-back from the unit
   input gr_wr_t gr_wr [2]
);
   logic [63:0] gr_val [128];
   logic gr_tok [128];

   // write-back; lane 1 applied last so it wins a clash
   always_ff @(posedge sys_clk)
   begin
      for (int l = 0; l < 2; l++)
      begin
         if (rst_b && gr_wr[l].valid && gr_wr[l].idx != 7'h00)
         begin
            gr_val[gr_wr[l].idx] <= gr_wr[l].data;
            gr_tok[gr_wr[l].idx] <= gr_wr[l].deferred_token_bit;
         end
      end
   end
endmodule : gen_reg_model

// file: test/test_predicate_compare_unit.sv
`timescale 1ns/1ps
`include "pcu_consts.svh"
// ---------------------------------------------
// bench for the predicate compare unit
// ---------------------------------------------
module test_predicate_compare_unit
   import pcu_pkg::*;
   ;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   op_t op [2];
   logic [63:0] pred_file;
   gr_wr_t gr_wr [2];
   logic [1:0] exec_en;
   logic [1:0] illegal;
   logic [1:0] f_ill;
   logic [1:0] f_ex;
   gr_wr_t f_gw;
   int fails = 0;
   int comparisons = 0;
   localparam logic [63:0] ONE = 64'h3FF0_0000_0000_0000;
   localparam logic [63:0] TWO = 64'h4000_0000_0000_0000;

   // core clock, 20 ns period
   always #10 sys_clk = ~sys_clk;

   // unit and register file model
   predicate_compare_unit u_predicate_compare_unit
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .op(op),
      .pred_file(pred_file),
      .gr_wr(gr_wr),
      .exec_en(exec_en),
      .illegal(illegal)
   );
   gen_reg_model u_gen_reg_model
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .gr_wr(gr_wr)
   );

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic chk(string n, logic [63:0] s, logic [63:0] e);
      comparisons++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic complete_run();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // targets default to predicates 10 and 11, source a not reg zero
   function automatic op_t mk(kind_t k, ctype_t c, logic [3:0] r,
      logic [5:0] q, logic [63:0] a, logic [63:0] b, logic [63:0] i);
      op_t o;
      o = '0;
      o.valid = 1'b1;
      o.kind = k;
      o.ctype = c;
      o.rel = r;
      o.qp = q;
      o.p1 = 6'h0A;
      o.p2 = 6'h0B;
      o.a_idx = 7'h04;
      o.dst = 7'h05;
      o.a = a;
      o.b = b;
      o.imm = i;
      return o;
   endfunction : mk

   // both targets as {first, second}
   function automatic logic [1:0] tg();
      return {pred_file[10], pred_file[11]};
   endfunction : tg

   // expected targets worked out from the type table
   function automatic logic [1:0] xp(ctype_t c, logic q, logic r,
      logic t, logic [1:0] o);
      if (t)
         return (c == CT_UNC || (q && c <= CT_ANDCM)) ? 2'b00 : o;
      if (!q)
         return (c == CT_UNC) ? 2'b00 : o;
      case (c)
         CT_NORM, CT_UNC: return {r, ~r};
         CT_AND: return r ? o : 2'b00;
         CT_ANDCM: return r ? 2'b00 : o;
         CT_OR: return r ? 2'b11 : o;
         CT_ORCM: return r ? o : 2'b11;
         CT_OR_ANDCM: return r ? 2'b10 : o;
         default: return r ? o : 2'b01;
      endcase
   endfunction : xp

   // one op per lane; flags land one edge later, predicates two
   task automatic go(op_t x, op_t y);
      @(posedge sys_clk);
      op[0] <= x;
      op[1] <= y;
      @(posedge sys_clk);
      op[0] <= '0;
      op[1] <= '0;
      #1;
      f_ill = illegal;
      f_ex = exec_en;
      f_gw = gr_wr[0];
      @(posedge sys_clk);
      #1;
   endtask : go

   // preset targets to {v, ~v}
   task automatic set2(logic v);
      go(mk(K_ICMP, CT_NORM, `REL_EQ, 6'h00, 64'h0, {63'h0, ~v},
         64'h0), '0);
   endtask : set2

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   // every type, qualifier, result, token and preset
   task automatic t_types();
      op_t o;
      o = mk(K_ICMP, CT_NORM, `REL_EQ, 6'h00, 64'h0, 64'h1, 64'h0);
      o.p1 = 6'h01;
      o.p2 = 6'h02;
      go(o, '0);
      for (int n = 0; n < 128; n++)
      begin
         set2(n[0]);
         o = mk(K_ICMP, ctype_t'(n[6:4]), `REL_EQ, {5'h00, ~n[1]},
            64'h0, {63'h0, ~n[2]}, 64'h0);
         o.a_nat = n[3];
         go(o, '0);
         chk("type", tg(), xp(ctype_t'(n[6:4]), n[1], n[2], n[3],
            {n[0], ~n[0]}));
         chk("type legal", f_ill, 2'b00);
      end
   endtask : t_types

   // relations, width, and refused type combinations
   task automatic t_rel();
      op_t o;
      op_t bad [4];
      for (int i = 0; i < 10; i++)
      begin
         go(mk(K_ICMP, CT_NORM, 4'(i), 6'h00, '1, 64'h1, 64'h0), '0);
         chk("relation", pred_file[10], 10'h30E >> i & 1);
      end
      for (int j = 0; j < 2; j++)
      begin
         o = mk(K_ICMP, CT_NORM, `REL_EQ, 6'h00,
            64'hFFFF_FFFF_0000_0005, 64'h5, 64'h0);
         o.is_32 = j[0];
         go(o, '0);
         chk("width", pred_file[10], j[0]);
      end
      bad[0] = mk(K_ICMP, CT_AND, `REL_LT, 6'h00, '1, 64'h0, 64'h0);
      bad[1] = mk(K_FCMP, CT_OR, `FREL_EQ, 6'h00, ONE, ONE, 64'h0);
      bad[2] = mk(K_RCPA, CT_NORM, 4'h0, 6'h00, ONE, TWO, 64'h0);
      bad[3] = bad[0];
      bad[3].b_zero = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         set2(1'b1);
         go(bad[k], '0);
         chk("refused", f_ill, {1'b0, k != 3});
         chk("refused keeps", tg(), 2'b10);
      end
   endtask : t_rel

   // bit test, flag test, float compare and classify
   task automatic t_bits();
      op_t o;
      logic [8:0] cm [4] = '{9'h013, 9'h023, 9'h100, 9'h013};
      logic [1:0] ce [4] = '{2'b10, 2'b01, 2'b10, 2'b00};
      for (int i = 0; i < 2; i++)
      begin
         go(mk(K_TBIT, CT_NORM, 4'h0, 6'h00, 64'h8000, 64'h0,
            64'(14 + i)), '0);
         chk("bit test", tg(), {i[0], ~i[0]});
         o = mk(K_TNAT, CT_NORM, 4'h0, 6'h00, 64'h0, 64'h0, 64'h0);
         o.a_nat = i[0];
         go(o, '0);
         chk("flag test", tg(), {i[0], ~i[0]});
      end
      set2(1'b0);
      go(mk(K_TBIT, CT_OR, 4'h0, 6'h00, 64'h8000, 64'h0, 64'h0F), '0);
      chk("bit or", tg(), 2'b11);
      go(mk(K_TBIT, CT_AND, 4'h0, 6'h00, 64'h8000, 64'h0, 64'h0E), '0);
      chk("bit and", tg(), 2'b00);
      for (int i = 0; i < 8; i++)
      begin
         go(mk(K_FCMP, CT_NORM, 4'(i), 6'h00, ONE, TWO, 64'h0), '0);
         chk("float rel", pred_file[10], 8'h96 >> i & 1);
      end
      for (int k = 0; k < 4; k++)
      begin
         o = mk(K_FCLASS, CT_NORM, 4'h0, 6'h00, ONE, 64'h0, 64'(cm[k]));
         o.a_nat = (k >= 2);
         go(o, '0);
         chk("classify", tg(), ce[k]);
      end
   endtask : t_bits

   // approximations write only the first target
   task automatic t_approx();
      op_t o;
      kind_t kd [7] = '{K_RCPA, K_RCPA, K_RCPA, K_RCPA, K_RSQA, K_RSQA,
         K_RCPA};
      logic [63:0] av [7] = '{ONE, ONE, ONE, 64'h0, ONE,
         64'hBFF0_0000_0000_0000, ONE};
      set2(1'b0);
      for (int k = 0; k < 7; k++)
      begin
         o = mk(kd[k], CT_UNC, 4'h0, {5'h00, k == 1}, av[k], TWO, 64'h0);
         o.a_nat = (k == 6);
         go(o, '0);
         chk("approx", tg(), {7'h15 >> k & 1, 1'b1});
      end
   endtask : t_approx

   // constant forming and register write-back
   task automatic t_gr();
      op_t o;
      o = mk(K_MOVL, CT_NORM, 4'h0, 6'h00, 64'h0, 64'h0,
         64'h0123_4567_89AB_CDEF);
      go(o, '0);
      chk("long move", f_gw.data, 64'h0123_4567_89AB_CDEF);
      chk("long move idx", {f_gw.valid, f_gw.idx}, 8'h85);
      chk("file", u_gen_reg_model.gr_val[5], o.imm);
      o = mk(K_ADDI22, CT_NORM, 4'h0, 6'h00, 64'hFFFF, 64'h0,
         64'h3F_FFFF);
      o.a_idx = 7'h00;
      go(o, '0);
      chk("zero reg add", f_gw.data, '1);
      o.a_idx = 7'h03;
      go(o, '0);
      chk("reg add", f_gw.data, 64'hFFFE);
      o.qp = 6'h01;
      go(o, '0);
      chk("gated add", f_gw.valid, 1'b0);
   endtask : t_gr

   // ungated control ops, lane merge, predicate zero
   task automatic t_misc();
      op_t o;
      op_t x;
      op_t y;
      for (int k = 0; k < 3; k++)
      begin
         o = mk(K_OTHER, CT_NORM, 4'h0, {5'h00, k != 2}, 64'h0, 64'h0,
            64'h0);
         o.unpred = (k == 0);
         go(o, '0);
         chk("exec", f_ex[0], k != 1);
      end
      set2(1'b0);
      x = mk(K_ICMP, CT_OR, `REL_EQ, 6'h00, 64'h0, 64'h0, 64'h0);
      y = x;
      y.b = 64'h1;
      go(x, y);
      chk("or merge", tg(), 2'b11);
      x.ctype = CT_AND;
      y.ctype = CT_AND;
      go(y, x);
      chk("and merge", tg(), 2'b00);
      o = mk(K_ICMP, CT_NORM, `REL_EQ, 6'h00, 64'h0, 64'h1, 64'h0);
      o.p1 = 6'h00;
      go(o, '0);
      chk("pred zero", pred_file[0], 1'b1);
   endtask : t_misc

   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      op[0] = '0;
      op[1] = '0;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("reset", pred_file, 64'h1);
      t_types();
      t_rel();
      t_bits();
      t_approx();
      t_gr();
      t_misc();
      complete_run();
   end

   // about 960 cycles expected; a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      complete_run();
   end
endmodule : test_predicate_compare_unit
